/* inc/dma_stream_pkg.sv */
// constants for the external dma and byte stream port
// assumes one 125 MHz system clock and a synchronous active-low reset
package dma_stream_pkg;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned SYNC_STAGES = 2;
	localparam logic [2:0] MARKER_BYTES = 3'h4;
	localparam logic MARKER_EN_RESET = 1'b1;
	localparam logic REQ_RESET = 1'b0;
	localparam int unsigned STREAM_HI = 31;
	localparam int unsigned STREAM_LO = 24;
	typedef enum logic [1:0] {
		XFER_IDLE,
		XFER_REQ,
		XFER_ACK
	} xfer_state_t;
endpackage

/* hw/dma_stream_port.sv */
// external dma handshake, chip-select fifo requests and compressed byte stream port
// assumes fifo status and stream data come from logic on clk_sys; pins pass two flops
`timescale 1ns/1ns
// Notes on behaviour
// [R1] hold input is only an input; its active level follows a polarity setting.
// [R2] host picks channel 0 or 1 fifo via its chip select in chip-select mode.
// [R3] request channel 1 whenever its fifo can send or take data.
// [R4] in chip-select mode the channel 1 request pin is a service request.
// [R5] host acknowledges channel 1 request, then the transfer goes ahead.
// [R6] host keeps channel 1 acknowledge high except during dma or stream access.
// [R7] unused dma interface: host ties channel 1 acknowledge high permanently.
// [R8] stream byte rides host data 31 to 24, bits 7..4 on 31..28.
// [R9] multichip align pin aligns outputs of several devices; tie low when unused. Here it only passes three flops to align_seen.
// [R10] encode mode, marker enabled: marker rises once a field's last word is read.
// [R11] on the byte stream the marker stays high for four consecutive bytes.
// [R12] marker is enabled after reset with no configuration.
// [R13] boot configuration input is captured at reset and selects the boot mode.
// [R14] request channel 0 whenever its fifo can send or take data.
// [R15] valid is always an output; its active level follows a polarity setting.
// [R16] drop channel 1 request when its fifo can neither accept nor supply.
module dma_stream_port (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic chip_select_dma_mode,
	input wire logic encode_mode,
	input wire logic marker_disable,
	input wire logic hold_polarity,
	input wire logic valid_polarity,
	input wire logic fifo0_ready,
	input wire logic fifo1_ready,
	input wire logic field_last_read,
	input wire logic [7:0] stream_out_byte,
	input wire logic stream_out_valid,
	input wire logic stream_enable,
	input wire logic transfer_ack_ch1,
	input wire logic fifo_select_ch0,
	input wire logic fifo_select_ch1,
	input wire logic stream_hold,
	input wire logic boot_cfg2,
	input wire logic multichip_align_in,
	input wire logic [31:0] host_data_in,
	output logic transfer_request_ch0,
	output logic transfer_request_ch1,
	output logic [31:0] host_data_out,
	output logic [31:0] host_data_oe,
	output logic stream_valid_pin,
	output logic field_end_marker_pin,
	output logic boot_mode,
	output logic align_seen,
	output logic stream_stalled,
	output logic [7:0] stream_in_byte,
	output logic stream_in_strobe,
	output logic ack1_seen
);
	import dma_stream_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [1:0] ack_sync;
		logic [1:0] cs0_sync;
		logic [1:0] cs1_sync;
		logic [1:0] hold_sync;
		logic [1:0] align_sync;
		logic [1:0] cfg_sync;
		logic boot_done;
		logic boot_mode;
		logic req0;
		logic req1;
		xfer_state_t st1;
		logic [2:0] marker_cnt;
		logic marker;
		logic [7:0] dout;
		logic doe;
		logic valid;
		logic stalled;
		logic align;
		logic [7:0] din;
		logic din_stb;
		logic ack_seen;
	} state_t;

	state_t q;
	state_t next_q;
	logic ack_low;
	logic cs0;
	logic cs1;
	logic hold_act;
	logic tx_byte;

	// synchronous level after the second flop, matched against a polarity bit
	function automatic logic active_at(input logic lvl, input logic pol);
		active_at = (lvl == pol);
	endfunction

	assign ack_low = ~q.ack_sync[1];
	assign cs0 = ~q.cs0_sync[1];
	assign cs1 = ~q.cs1_sync[1];
	// [R1] hold polarity
	assign hold_act = active_at(q.hold_sync[1], hold_polarity);
	assign tx_byte = stream_enable && stream_out_valid && !hold_act;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_q = q;
		next_q.ack_sync = {q.ack_sync[0], transfer_ack_ch1};
		next_q.cs0_sync = {q.cs0_sync[0], fifo_select_ch0};
		next_q.cs1_sync = {q.cs1_sync[0], fifo_select_ch1};
		next_q.hold_sync = {q.hold_sync[0], stream_hold};
		next_q.align_sync = {q.align_sync[0], multichip_align_in};
		next_q.cfg_sync = {q.cfg_sync[0], boot_cfg2};
		// [R13] capture boot strap
		if (!q.boot_done) begin
			next_q.boot_done = 1'b1;
			next_q.boot_mode = q.cfg_sync[1];
		end
		// [R9] align pin sampled
		next_q.align = q.align_sync[1];
		// [R14] channel 0 request
		next_q.req0 = chip_select_dma_mode ? (fifo0_ready && !cs0) : fifo0_ready;
		// [R3] channel 1 handshake
		case (q.st1)
			XFER_IDLE: begin
				if (fifo1_ready) begin
					next_q.st1 = XFER_REQ;
				end
			end
			XFER_REQ: begin
				if (ack_low) begin
					next_q.st1 = XFER_ACK;
				end else if (!fifo1_ready) begin
					next_q.st1 = XFER_IDLE;
				end
			end
			XFER_ACK: begin
				if (!ack_low) begin
					next_q.st1 = fifo1_ready ? XFER_REQ : XFER_IDLE;
				end
			end
			default: begin
				next_q.st1 = XFER_IDLE;
			end
		endcase
		next_q.ack_seen = (q.st1 == XFER_ACK);
		// [R4] service request in chip-select mode
		if (chip_select_dma_mode) begin
			next_q.req1 = fifo1_ready && !cs1;
		end else begin
			// [R16] drop request when fifo stuck
			next_q.req1 = (next_q.st1 != XFER_IDLE) && fifo1_ready;
		end
		// [R8] stream byte on upper host lines
		next_q.doe = stream_enable && encode_mode;
		next_q.stalled = stream_enable && hold_act;
		if (tx_byte) begin
			next_q.dout = stream_out_byte;
		end
		// [R15] valid with polarity
		next_q.valid = valid_polarity ? tx_byte : !tx_byte;
		next_q.din_stb = stream_enable && !encode_mode && !hold_act && ack_low;
		if (next_q.din_stb) begin
			next_q.din = host_data_in[STREAM_HI:STREAM_LO];
		end
		// [R10] marker rises after last word of field
		if (encode_mode && !marker_disable && field_last_read) begin
			next_q.marker_cnt = MARKER_BYTES;
			next_q.marker = 1'b1;
		end else if (q.marker && tx_byte) begin
			// [R11] four bytes long
			next_q.marker_cnt = q.marker_cnt - 3'h1;
			next_q.marker = (q.marker_cnt != 3'h1);
		end
		if (!rst_n) begin
			next_q = '0;
			next_q.ack_sync = 2'h3;
			next_q.cs0_sync = 2'h3;
			next_q.cs1_sync = 2'h3;
			// [R13] strap sync runs through reset
			next_q.cfg_sync = {q.cfg_sync[0], boot_cfg2};
			next_q.req0 = REQ_RESET;
			next_q.req1 = REQ_RESET;
			next_q.st1 = XFER_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		q <= next_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// [R12] marker on by default; only a disable input exists
	logic marker_en;
	assign marker_en = MARKER_EN_RESET & ~marker_disable;

	assign transfer_request_ch0 = q.req0;
	assign transfer_request_ch1 = q.req1;
	assign host_data_out = {q.dout, 24'h000000};
	assign host_data_oe = {{8{q.doe}}, 24'h000000};
	assign stream_valid_pin = q.valid;
	assign field_end_marker_pin = q.marker;
	assign boot_mode = q.boot_mode;
	assign align_seen = q.align;
	assign stream_stalled = q.stalled;
	assign stream_in_byte = q.din;
	assign stream_in_strobe = q.din_stb;
	assign ack1_seen = q.ack_seen;

	////////////////////////////////////////////////////////////////////////////////
	property p_marker_rise;
		@(posedge clk_sys) disable iff (!rst_n)
		(encode_mode && marker_en && field_last_read) |=> field_end_marker_pin;
	endproperty
	a_marker_rise: assert property (p_marker_rise) else $error("marker did not rise"); // [R10]

	property p_marker_len;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(field_end_marker_pin) && !field_last_read && !tx_byte)
		|-> (q.marker_cnt == MARKER_BYTES);
	endproperty
	a_marker_len: assert property (p_marker_len) else $error("marker count not four"); // [R11]

	property p_marker_default;
		@(posedge clk_sys) (!rst_n ##1 rst_n && encode_mode && field_last_read
			&& !marker_disable) |=> field_end_marker_pin;
	endproperty
	a_marker_default: assert property (p_marker_default) else $error("marker off"); // [R12]

	property p_req1_drop;
		@(posedge clk_sys) disable iff (!rst_n)
		(!fifo1_ready) |=> !transfer_request_ch1;
	endproperty
	a_req1_drop: assert property (p_req1_drop) else $error("ch1 request held"); // [R16]

	property p_req1_set;
		@(posedge clk_sys) disable iff (!rst_n)
		(!chip_select_dma_mode && fifo1_ready && q.st1 == XFER_REQ)
		|=> transfer_request_ch1;
	endproperty
	a_req1_set: assert property (p_req1_set) else $error("ch1 request missing"); // [R3]

	property p_srq1;
		@(posedge clk_sys) disable iff (!rst_n)
		(chip_select_dma_mode && fifo1_ready && !cs1) |=> transfer_request_ch1;
	endproperty
	a_srq1: assert property (p_srq1) else $error("ch1 service request missing"); // [R4]

	property p_req0;
		@(posedge clk_sys) disable iff (!rst_n)
		(!chip_select_dma_mode) |=> (transfer_request_ch0 == $past(fifo0_ready));
	endproperty
	a_req0: assert property (p_req0) else $error("ch0 request wrong"); // [R14]

	property p_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(stream_enable && hold_act) |=> stream_stalled;
	endproperty
	a_hold: assert property (p_hold) else $error("hold ignored"); // [R1]

	property p_valid;
		@(posedge clk_sys) disable iff (!rst_n)
		tx_byte |=> (stream_valid_pin == $past(valid_polarity));
	endproperty
	a_valid: assert property (p_valid) else $error("valid polarity wrong"); // [R15]

	property p_lanes;
		@(posedge clk_sys) disable iff (!rst_n)
		tx_byte |=> (host_data_out[31:28] == $past(stream_out_byte[7:4]));
	endproperty
	a_lanes: assert property (p_lanes) else $error("stream lanes wrong"); // [R8]

	c_marker: cover property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(field_end_marker_pin));
	c_ack: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(ack1_seen));
	c_stall: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(stream_stalled));
endmodule

/* tb/dma_host_model.sv */
// host side model: answers channel 1 requests with an active-low acknowledge
// assumes the port samples its pins on clk_sys
`timescale 1ns/1ns
module dma_host_model (
	input wire logic clk_sys,
	input wire logic transfer_request_ch1,
	input wire logic slow,
	input wire logic cs_access,
	output logic transfer_ack_ch1,
	output logic fifo_select_ch0,
	output logic fifo_select_ch1
);
	logic [1:0] wait_cnt = 2'h0;
	initial transfer_ack_ch1 = 1'b1;
	assign fifo_select_ch0 = 1'b1;
	assign fifo_select_ch1 = !cs_access;
	// ack low only for a pending request
	always @(posedge clk_sys) begin
		wait_cnt <= transfer_request_ch1 ? wait_cnt + 2'h1 : 2'h0;
		transfer_ack_ch1 <= !(transfer_request_ch1 && (!slow || wait_cnt == 2'h3));
	end
endmodule

/* tb/external_dma_and_byte_stream_port_tb_top.sv */
// bench for the dma handshake and byte stream port
// assumes the host model stands on the channel 1 handshake pins
`timescale 1ns/1ns
module external_dma_and_byte_stream_port_tb_top;
	import dma_stream_pkg::*;
	logic clk_sys = 0, rst_n = 0, csm = 0, enc = 1, mdis = 0, hpol = 1, vpol = 1;
	logic f0 = 0, f1 = 0, last = 0, sv = 0, sen = 1, hold = 0, boot = 1, align = 0;
	logic slow = 0, cs_acc = 0, ack1, sel0, sel1, req0, req1, vpin, mpin, bmode, aseen;
	logic stall, istb, aseen1;
	logic [7:0] sbyte = 8'h00;
	logic [7:0] ibyte;
	logic [31:0] dout, oe;
	int fails = 0, checked = 0, cyc = 0;
	always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
	dma_host_model host (.clk_sys(clk_sys), .transfer_request_ch1(req1), .slow(slow),
		.cs_access(cs_acc), .transfer_ack_ch1(ack1), .fifo_select_ch0(sel0),
		.fifo_select_ch1(sel1));
	dma_stream_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .chip_select_dma_mode(csm),
		.encode_mode(enc), .marker_disable(mdis), .hold_polarity(hpol),
		.valid_polarity(vpol), .fifo0_ready(f0), .fifo1_ready(f1), .field_last_read(last),
		.stream_out_byte(sbyte), .stream_out_valid(sv), .stream_enable(sen),
		.transfer_ack_ch1(ack1), .fifo_select_ch0(sel0), .fifo_select_ch1(sel1),
		.stream_hold(hold), .boot_cfg2(boot), .multichip_align_in(align),
		.host_data_in({sbyte, 24'h000000}), .transfer_request_ch0(req0),
		.transfer_request_ch1(req1), .host_data_out(dout), .host_data_oe(oe),
		.stream_valid_pin(vpin), .field_end_marker_pin(mpin), .boot_mode(bmode),
		.align_seen(aseen), .stream_stalled(stall), .stream_in_byte(ibyte),
		.stream_in_strobe(istb), .ack1_seen(aseen1));
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wait_for(ref logic s, input logic v);
		int n = 0;
		while (s !== v && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_handshake();
		for (int k = 0; k < 2; k++) begin
			slow = k[0];
			f1 = 1;
			wait_for(req1, 1);
			chk("req1", 1, req1);
			wait_for(aseen1, 1);
			chk("ack1_seen", 1, aseen1);
			f1 = 0;
			tick(3);
			chk("req1 off", 0, req1);
			wait_for(aseen1, 0);
			chk("ack1_seen off", 0, aseen1);
		end
		f0 = 1;
		tick(3);
		chk("req0", 1, req0);
		f0 = 0;
	endtask
	task automatic t_stream();
		sv = 1;
		sbyte = 8'hC3;
		tick(1);
		sv = 0;
		chk("dout", 32'hC3000000, dout);
		chk("oe", 8'hFF, oe[31:24]);
		chk("valid", 1, vpin);
		vpol = 0;
		tick(2);
		chk("valid idle low pol", 1, vpin);
		vpol = 1;
		hold = 1;
		tick(4);
		chk("stall", 1, stall);
		sv = 1;
		tick(1);
		sv = 0;
		chk("valid held", 0, vpin);
		hold = 0;
		hpol = 0;
		tick(4);
		chk("stall low pol", 1, stall);
		hpol = 1;
		tick(4);
	endtask
	task automatic t_marker();
		last = 1;
		tick(1);
		last = 0;
		wait_for(mpin, 1);
		chk("marker", 1, mpin);
		sv = 1;
		tick(3);
		chk("marker 3 bytes", 1, mpin);
		tick(1);
		sv = 0;
		tick(2);
		chk("marker end", 0, mpin);
		mdis = 1;
		last = 1;
		tick(1);
		last = 0;
		tick(3);
		chk("marker off", 0, mpin);
		mdis = 0;
		rst_n = 0;
		tick(2);
		rst_n = 1;
		last = 1;
		tick(1);
		last = 0;
		chk("marker after reset", 1, mpin);
		chk("boot_mode again", 1, bmode);
	endtask
	task automatic t_chip_select();
		csm = 1;
		f1 = 1;
		f0 = 1;
		tick(5);
		chk("service req", 1, req1);
		chk("service req0", 1, req0);
		cs_acc = 1;
		tick(5);
		chk("service req sel", 0, req1);
		cs_acc = 0;
		f1 = 0;
		f0 = 0;
		csm = 0;
		align = 1;
		tick(4);
		chk("align", 1, aseen);
	endtask
	task automatic t_stream_in();
		enc = 0;
		sbyte = 8'h5A;
		f1 = 1;
		wait_for(istb, 1);
		chk("in strobe", 1, istb);
		chk("in byte", 8'h5A, ibyte);
		chk("oe decode", 0, oe[31:24]);
		f1 = 0;
		tick(2);
		enc = 1;
		tick(4);
	endtask
	initial begin
		tick(5);
		rst_n = 1;
		tick(4);
		chk("boot_mode", 1, bmode);
		t_handshake();
		t_stream();
		t_marker();
		t_chip_select();
		t_stream_in();
		report_and_stop();
	end
endmodule
